// [hdl/pmic_protect_sequence_ctrl.v]
// protection gating, enable sequencing and avalon register slave
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pmic_seq_regs.vh"
module pmic_protect_sequence_ctrl #(
   parameter BACKUP_CYC = `BACKUP_DELAY_CYC,
   parameter USB_CYC    = `USB_DELAY_CYC,
   parameter START_CNT  = `START_PULSES
) (
   input  wire        clk_i,
   input  wire        rstn_i,
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire        power_on_request_i,
   input  wire        usb_ldo_enable_pin_i,
   input  wire        reconf_channel_mode_pin_i,
   input  wire        system_power_down_i,
   input  wire        pwm_pulse_i,
   input  wire        thermal_flag_i,
   input  wire [5:0]  short_flag_i,
   input  wire [3:0]  ovp_flag_i,
   input  wire        backlight_ocp_i,
   input  wire        motor_ss_cmp_i,
   input  wire        reconf_above_aon_i,
   input  wire        core_supply_ok_i,
   input  wire        aon_supply_ok_i,
   output reg  [6:0]  ch_enable_o,
   output reg  [6:0]  ch_switch_o,
   output reg         backlight_discharge_o,
   output reg         backup_ldo_on_o,
   output reg         usb_ldo_on_o,
   output reg         display_ldo_on_o,
   output reg         aon_full_mode_o,
   output reg         reconf_isolation_gate_out_o,
   output reg         reconf_sync_rect_o,
   output reg         reconf_step_up_o,
   output reg         subcpu_reset_n_o,
   output reg         supply_good_o
);
   // channel index: 0 io,1 core,2 motor,3 lcd,4 inv,5 backlight,6 reconf
   // ovp index: 0 core,1 motor,2 backlight,3 reconf
   localparam ST_IDLE  = 2'h0;
   localparam ST_WAIT  = 2'h1;
   localparam ST_MOTOR = 2'h2;
   localparam ST_RUN   = 2'h3;

   wire [20:0] pin_q;
   wire        pon;
   wire        usb_pin;
   wire        mode_up;
   wire        pdown;
   wire        pwm;
   wire        tsd;
   wire [5:0]  scp;
   wire [3:0]  ovp;
   wire        ocp;
   wire        ss_cmp;
   wire        above;
   wire        core_ok;
   wire        aon_ok;

   pin_sync #(
      .W (21)
   ) u_sync (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .d_i    ({power_on_request_i, usb_ldo_enable_pin_i,
                reconf_channel_mode_pin_i, system_power_down_i,
                pwm_pulse_i, thermal_flag_i, short_flag_i, ovp_flag_i,
                backlight_ocp_i, motor_ss_cmp_i, reconf_above_aon_i,
                core_supply_ok_i, aon_supply_ok_i}),
      .q_o    (pin_q)
   );
   assign {pon, usb_pin, mode_up, pdown, pwm, tsd, scp, ovp, ocp,
           ss_cmp, above, core_ok, aon_ok} = pin_q;

   reg [15:0] ctrl_reg;
   reg        pon_d_reg;
   reg        pdown_d_reg;
   reg        pwm_d_reg;
   reg        aon_d_reg;
   reg        logic_rst_reg;
   reg [1:0]  state_reg;
   reg [9:0]  pulse_reg;
   reg [17:0] bk_cnt_reg;
   reg [18:0] usb_cnt_reg;
   reg        bk_done_reg;
   reg        usb_done_reg;
   reg        ov_latch_reg;
   reg        fault_reg;
   reg        sync_rect_reg;
   reg        ss_done_reg;

   wire pon_rise   = pon & ~pon_d_reg;
   wire pdown_fall = ~pdown & pdown_d_reg;
   wire pwm_rise   = pwm & ~pwm_d_reg;
   wire fault_now  = tsd | (|scp);
   wire [6:0] ch_bits = ctrl_reg[`CTRL_CH_EN_LSB +: 7];

   // bus slave: one wait cycle, then answer
   wire req = avs_read | avs_write;
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else begin
         avs_waitrequest <= ~(req & avs_waitrequest);
         if (avs_read & avs_waitrequest) begin
            case (avs_address)
               `CTRL_ADDR: avs_readdata <= {16'h0000, ctrl_reg};
               `STAT_ADDR: avs_readdata <= {16'h0000, state_reg,
                              usb_done_reg, bk_done_reg, ss_done_reg,
                              sync_rect_reg, ov_latch_reg, fault_reg,
                              tsd, scp, ocp};
               default:    avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   always @(posedge clk_i) begin
      if (!rstn_i)
         ctrl_reg <= `CTRL_RESET;
      else if (avs_write & ~avs_waitrequest & (avs_address == `CTRL_ADDR))
         ctrl_reg <= avs_writedata[15:0];
   end

   // edge history and internal reset at supply-good
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         pon_d_reg     <= 1'b0;
         pdown_d_reg   <= 1'b0;
         pwm_d_reg     <= 1'b0;
         aon_d_reg     <= 1'b0;
         logic_rst_reg <= 1'b1;
      end else begin
         pon_d_reg     <= pon;
         pdown_d_reg   <= pdown;
         pwm_d_reg     <= pwm;
         aon_d_reg     <= aon_ok;
         logic_rst_reg <= ~aon_ok | (aon_ok & ~aon_d_reg);
      end
   end

   // post supply-good delay counters
   always @(posedge clk_i) begin
      if (!rstn_i || logic_rst_reg) begin
         bk_cnt_reg   <= 18'h00000;
         usb_cnt_reg  <= 19'h00000;
         bk_done_reg  <= 1'b0;
         usb_done_reg <= 1'b0;
      end else begin
         if (!bk_done_reg) begin
            bk_cnt_reg  <= bk_cnt_reg + 18'h00001;
            bk_done_reg <= (bk_cnt_reg == BACKUP_CYC - 1);
         end
         if (!usb_done_reg) begin
            usb_cnt_reg  <= usb_cnt_reg + 19'h00001;
            usb_done_reg <= (usb_cnt_reg == USB_CYC - 1);
         end
      end
   end

   // start sequence
   always @(posedge clk_i) begin
      if (!rstn_i || logic_rst_reg) begin
         state_reg   <= ST_IDLE;
         pulse_reg   <= 10'h000;
         ss_done_reg <= 1'b0;
      end else if (pdown_fall || !pon) begin
         state_reg   <= ST_IDLE;
         pulse_reg   <= 10'h000;
         ss_done_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (pon_rise) begin
                  state_reg <= ST_WAIT;
                  pulse_reg <= 10'h000;
               end
            end
            ST_WAIT: begin
               if (pwm_rise) begin
                  if (pulse_reg == START_CNT - 1)
                     state_reg <= ST_MOTOR;
                  pulse_reg <= pulse_reg + 10'h001;
               end
            end
            ST_MOTOR: begin
               if (ss_cmp) begin
                  ss_done_reg <= 1'b1;
                  state_reg   <= ST_RUN;
               end
            end
            ST_RUN: state_reg <= ST_RUN;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // protection latches
   always @(posedge clk_i) begin
      if (!rstn_i || logic_rst_reg) begin
         ov_latch_reg <= 1'b0;
         fault_reg    <= 1'b0;
      end else begin
         if (ovp[2])
            ov_latch_reg <= 1'b1;
         else if (!pon)
            ov_latch_reg <= 1'b0;
         if (fault_now)
            fault_reg <= 1'b1;
         else if (!pon)
            fault_reg <= 1'b0;
      end
   end

   // reconf rectification mode
   always @(posedge clk_i) begin
      if (!rstn_i || logic_rst_reg)
         sync_rect_reg <= 1'b0;
      else if (!ch_enable_o[6])
         sync_rect_reg <= 1'b0;
      else if (above)
         sync_rect_reg <= 1'b1;
   end

   // registered outputs
   reg [6:0] en_next;
   reg [6:0] sw_next;
   always @* begin
      en_next = 7'h00;
      if (state_reg == ST_MOTOR)
         en_next[2] = ch_bits[2];
      else if (state_reg == ST_RUN)
         en_next = ch_bits;
      if (fault_reg | fault_now)
         en_next = 7'h00;
      if (ov_latch_reg | ovp[2])
         en_next[5] = 1'b0;
      sw_next = en_next;
      sw_next[1] = en_next[1] & ~ovp[0];
      sw_next[2] = en_next[2] & ~ovp[1];
      sw_next[6] = en_next[6] & ~ovp[3];
      sw_next[5] = en_next[5] & ~ocp;
   end

   always @(posedge clk_i) begin
      if (!rstn_i) begin
         ch_enable_o                 <= 7'h00;
         ch_switch_o                 <= 7'h00;
         backlight_discharge_o       <= 1'b0;
         backup_ldo_on_o             <= 1'b0;
         usb_ldo_on_o                <= 1'b0;
         display_ldo_on_o            <= 1'b0;
         aon_full_mode_o             <= 1'b0;
         reconf_isolation_gate_out_o <= 1'b0;
         reconf_sync_rect_o          <= 1'b0;
         reconf_step_up_o            <= 1'b0;
         subcpu_reset_n_o            <= 1'b0;
         supply_good_o               <= 1'b0;
      end else begin
         ch_enable_o           <= en_next;
         ch_switch_o           <= sw_next;
         backlight_discharge_o <= ov_latch_reg | ocp;
         backup_ldo_on_o       <= ctrl_reg[`CTRL_BACKUP_BIT] &
                                  bk_done_reg;
         usb_ldo_on_o          <= usb_done_reg & usb_pin;
         display_ldo_on_o      <= ctrl_reg[`CTRL_DISPLAY_BIT] &
                                  ~fault_reg & ~fault_now;
         aon_full_mode_o       <= pon;
         reconf_isolation_gate_out_o <= mode_up &
                                  ctrl_reg[`CTRL_ISO_BIT];
         reconf_sync_rect_o    <= sync_rect_reg & en_next[6];
         reconf_step_up_o      <= mode_up;
         subcpu_reset_n_o      <= core_ok;
         supply_good_o         <= aon_ok;
      end
   end
endmodule

// [pkg/pmic_seq_regs.vh]
// constants, register map and timing counts for the power sequencer
`ifndef PMIC_SEQ_REGS_VH
`define PMIC_SEQ_REGS_VH
`define CTRL_ADDR          4'h0
`define STAT_ADDR          4'h1
`define CTRL_RESET         16'h01FF
`define CTRL_CH_EN_LSB     0
`define CTRL_BACKUP_BIT    7
`define CTRL_DISPLAY_BIT   8
`define CTRL_ISO_BIT       9
`define CLK_MHZ            200
`define BACKUP_DELAY_NS    30000
`define USB_DELAY_NS       1030000
`define BACKUP_DELAY_CYC   ((`BACKUP_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define USB_DELAY_CYC      ((`USB_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define START_PULSES       544
`endif

// [hdl/pin_sync.v]
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
   parameter W = 1
) (
   input  wire         clk_i,
   input  wire         rstn_i,
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;
   genvar i;
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
         s3_reg <= {W{1'b0}};
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg q_bit_reg;
         always @(posedge clk_i) begin
            if (!rstn_i)
               q_bit_reg <= 1'b0;
            else if (s2_reg[i] == s3_reg[i])
               q_bit_reg <= s3_reg[i];
         end
         assign q_o[i] = q_bit_reg;
      end
   endgenerate
endmodule

// [bench/subcpu_model.sv]
// sub-processor model driving the power-on request
`timescale 1ns/1ps
module subcpu_model (
   input  wire logic clk_i,
   input  wire logic want_i,
   input  wire logic core_en_i,
   output logic      power_on_o
);
   logic core_q = 1'b0;
   logic lost   = 1'b0;
   always @(posedge clk_i) begin
      core_q <= core_en_i;
      if (!want_i)
         lost <= 1'b0;
      else if (core_q && !core_en_i)
         lost <= 1'b1;
      power_on_o <= want_i && !lost;
   end
endmodule

// [bench/pmic_seq_sva.sv]
// port checks for the power sequencer
`timescale 1ns/1ps
module pmic_seq_sva #(
   parameter int USB_CYC = 206000
) (
   input logic       clk_i,
   input logic       rstn_i,
   input logic       thermal_flag_i,
   input logic [5:0] short_flag_i,
   input logic [3:0] ovp_flag_i,
   input logic       backlight_ocp_i,
   input logic       power_on_request_i,
   input logic       aon_supply_ok_i,
   input logic       usb_ldo_enable_pin_i,
   input logic       system_power_down_i,
   input logic [6:0] ch_enable_o,
   input logic [6:0] ch_switch_o,
   input logic       backlight_discharge_o,
   input logic       usb_ldo_on_o,
   input logic       aon_full_mode_o
);
   int up_cnt;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // cycles since supply good
   always @(posedge clk_i)
      if (!rstn_i || !aon_supply_ok_i)
         up_cnt <= 0;
      else if (up_cnt < 2000000)
         up_cnt <= up_cnt + 1;
   tsd_off_a: assert property (thermal_flag_i [*8] |-> ch_enable_o == 0)
      else $error("channel on under thermal flag");
   scp_off_a: assert property ((|short_flag_i)[*8] |-> ch_enable_o == 0)
      else $error("channel on under short flag");
   ovp_set_a: assert property (
      (ovp_flag_i[2] && power_on_request_i) [*8]
      |-> backlight_discharge_o && !ch_switch_o[5])
      else $error("backlight overvoltage not acted on");
   ovp_keep_a: assert property (
      (ovp_flag_i[2] && power_on_request_i) [*8]
      ##1 (!ovp_flag_i[2] && power_on_request_i && aon_supply_ok_i) [*8]
      |-> backlight_discharge_o)
      else $error("backlight latch cleared early");
   ov_auto_a: assert property (ovp_flag_i[1] [*8] |-> !ch_switch_o[2])
      else $error("motor switching under overvoltage");
   ocp_gate_a: assert property (backlight_ocp_i [*8]
      |-> backlight_discharge_o && !ch_switch_o[5])
      else $error("backlight overcurrent not acted on");
   usb_wait_a: assert property (usb_ldo_on_o |-> up_cnt >= USB_CYC)
      else $error("usb regulator on too early");
   usb_pin_a: assert property (
      !usb_ldo_enable_pin_i [*8] |-> !usb_ldo_on_o)
      else $error("usb regulator on with pin low");
   skip_mode_a: assert property (
      !power_on_request_i [*8] |-> !aon_full_mode_o)
      else $error("full mode with power-on low");
   motor_first_a: assert property (
      $rose(|ch_enable_o) |-> ch_enable_o == 7'h04)
      else $error("motor channel not first");
   power_down_a: assert property ($fell(system_power_down_i)
      |-> ##[1:8] ch_enable_o == 0)
      else $error("channels on after power-down");
   cover property (usb_ldo_on_o);
   cover property ($rose(ch_enable_o[2]));
   cover property (backlight_discharge_o && !backlight_ocp_i);
endmodule
bind pmic_protect_sequence_ctrl pmic_seq_sva #(.USB_CYC(USB_CYC)) u_sva (.*);

// [bench/test_pmic_protect_sequence_ctrl.sv]
// self-checking bench for the power sequencer
`timescale 1ns/1ps
module test_pmic_protect_sequence_ctrl;
   logic        clk_i = 0, rstn_i = 0, avs_read = 0, avs_write = 0, want = 0;
   logic [3:0]  avs_address = 0, ovp_flag_i = 0;
   logic [31:0] avs_writedata = 0, rdata;
   logic [5:0]  short_flag_i = 0;
   logic [2:0]  pc = 0;
   logic usb_ldo_enable_pin_i = 0, reconf_channel_mode_pin_i = 0;
   logic system_power_down_i = 0, thermal_flag_i = 0, backlight_ocp_i = 0;
   logic motor_ss_cmp_i = 0, reconf_above_aon_i = 0;
   logic core_supply_ok_i = 0, aon_supply_ok_i = 0;
   int   n_fail = 0, check_count = 0, cyc = 0, tn = 0, f;
   wire  pwm_pulse_i = pc[2];
   wire [31:0] avs_readdata;
   wire [6:0]  ch_enable_o, ch_switch_o;
   wire avs_waitrequest, power_on_request_i, backlight_discharge_o;
   wire backup_ldo_on_o, usb_ldo_on_o, display_ldo_on_o, aon_full_mode_o;
   wire reconf_isolation_gate_out_o, reconf_sync_rect_o, reconf_step_up_o;
   wire subcpu_reset_n_o, supply_good_o;
   pmic_protect_sequence_ctrl #(.BACKUP_CYC(20), .USB_CYC(60), .START_CNT(4))
      u_dut (.*);
   subcpu_model u_cpu (.clk_i(clk_i), .want_i(want),
      .core_en_i(ch_enable_o[1]), .power_on_o(power_on_request_i));
   initial forever #2.5 clk_i = ~clk_i;
   // slow pulse train and run ceiling
   always @(posedge clk_i) begin
      pc <= pc + 3'h1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         test_done;
      end
   end
   task test_done;
      begin
         $display("checks %0d mismatches %0d", check_count, n_fail);
         if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         check_count++;
         if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task tend;
      begin
         tn++;
         $display("test %0d finished", tn);
      end
   endtask
   task bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
      begin
         avs_address <= a;
         avs_writedata <= d;
         avs_read <= rd;
         avs_write <= !rd;
         do begin
            @(posedge clk_i);
         end while (avs_waitrequest !== 1'b0);
         rdata = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   task up;
      int k;
      begin
         want <= 1'b1;
         for (k = 0; k < 500 && ch_enable_o !== 7'h04; k++)
            @(posedge clk_i);
         chk(32'(ch_enable_o), 32'h04);
         motor_ss_cmp_i <= 1'b1;
         tick(10);
         chk(32'(ch_enable_o), 32'h7F);
      end
   endtask
   task down;
      begin
         want <= 1'b0;
         motor_ss_cmp_i <= 1'b0;
         tick(10);
         chk(32'({ch_enable_o, aon_full_mode_o}), 32'h0);
      end
   endtask
   initial begin
      tick(12);
      rstn_i <= 1'b1;
      bus(1'b1, 4'h0, 32'h0);
      chk(rdata, 32'h000001FF);
      bus(1'b0, 4'hF, 32'hFFFFFFFF);
      bus(1'b1, 4'hF, 32'h0);
      chk(rdata, 32'h0);
      aon_supply_ok_i <= 1'b1;
      core_supply_ok_i <= 1'b1;
      usb_ldo_enable_pin_i <= 1'b1;
      tick(10);
      chk(32'({supply_good_o, subcpu_reset_n_o, backup_ldo_on_o,
         usb_ldo_on_o}), 32'hC);
      tend;
      up;
      tick(60);
      chk(32'({aon_full_mode_o, backup_ldo_on_o, usb_ldo_on_o,
         display_ldo_on_o}), 32'hF);
      // status: run state, all delays and soft-start done, no faults
      bus(1'b1, 4'h1, 32'h0);
      chk(rdata, 32'h0000F800);
      usb_ldo_enable_pin_i <= 1'b0;
      reconf_channel_mode_pin_i <= 1'b1;
      bus(1'b0, 4'h0, 32'h000002FF);
      tick(10);
      chk(32'({usb_ldo_on_o, display_ldo_on_o, reconf_isolation_gate_out_o,
         reconf_step_up_o, reconf_sync_rect_o}), 32'h6);
      reconf_above_aon_i <= 1'b1;
      bus(1'b0, 4'h0, 32'h000001FF);
      tick(10);
      chk(32'({reconf_isolation_gate_out_o, reconf_sync_rect_o}),
         32'h1);
      tend;
      ovp_flag_i <= 4'hB;
      tick(10);
      chk(32'(ch_switch_o), 32'h39);
      ovp_flag_i <= 4'h0;
      backlight_ocp_i <= 1'b1;
      tick(10);
      chk(32'({backlight_discharge_o, ch_switch_o}), 32'hDF);
      backlight_ocp_i <= 1'b0;
      tick(10);
      chk(32'({backlight_discharge_o, ch_switch_o}), 32'h7F);
      ovp_flag_i <= 4'h4;
      tick(10);
      chk(32'({backlight_discharge_o, ch_switch_o}), 32'hDF);
      ovp_flag_i <= 4'h0;
      tick(10);
      chk(32'({backlight_discharge_o, ch_switch_o}), 32'hDF);
      down;
      chk(32'(backlight_discharge_o), 32'h0);
      tend;
      for (f = 0; f < 2; f++) begin
         up;
         thermal_flag_i <= (f == 0);
         short_flag_i <= (f == 1) ? 6'h08 : 6'h00;
         tick(20);
         chk(32'({ch_enable_o, aon_full_mode_o}), 32'h0);
         thermal_flag_i <= 1'b0;
         short_flag_i <= 6'h00;
         down;
         tend;
      end
      up;
      system_power_down_i <= 1'b1;
      tick(10);
      system_power_down_i <= 1'b0;
      tick(10);
      chk(32'(ch_enable_o), 32'h00);
      down;
      core_supply_ok_i <= 1'b0;
      tick(10);
      chk(32'(subcpu_reset_n_o), 32'h0);
      tend;
      test_done;
   end
endmodule
